// ---- design/clhp_top.sv ----
// host port, pointer, prefetch and display shift of the character controller
`timescale 1ns/1ps
`default_nettype none
`include "clhp_params.svh"
module clhp_top (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_core_ce,
  input wire logic i_register_select,
  input wire logic i_rw_select,
  input wire logic i_strobe,
  input wire logic [7:0] i_host_bus,
  output logic [7:0] o_host_bus,
  output logic [7:0] o_host_bus_oe,
  input wire logic i_clock_in_pad,
  input wire logic i_ext_osc_en,
  input wire logic i_reset_pad_b,
  input wire logic i_pad_order_select,
  output logic o_pad_order_mirror,
  output logic o_line_layout_select,
  output logic o_addr_split,
  output logic [6:0] o_line1_start,
  output logic [6:0] o_line2_start,
  output logic o_wait_flag
);
  localparam int P_RS = 8;
  localparam int P_RW = 9;
  localparam int P_E = 10;
  localparam int P_RST = 11;
  localparam int P_OSC = 12;
  localparam int P_PAD = 13;
  localparam int P_EXT = 14;
  localparam logic [14:0] SYN_RST = 15'h0800;
  localparam logic [7:0] OSC_LAST = 8'(`CLHP_OSC_DIV - 1);
  localparam logic [8:0] RST_TICKS = 9'(`CLHP_RST_TICKS);
  localparam logic [3:0] BUSY_LAST = 4'(`CLHP_BUSY_TICKS - 1);

  // split layout: ring position 0..15 maps to 00-07 then 40-47
  function automatic logic [6:0] ring_addr(input logic [3:0] r);
    ring_addr = {r[3], 3'h0, r[2:0]};
  endfunction

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up,
                                          input logic glyph, input logic split);
    logic [4:0] g;
    logic [3:0] c;
    logic [3:0] r;
    g = up ? p[4:0] + 5'h01 : p[4:0] - 5'h01;
    c = up ? p[3:0] + 4'h1 : p[3:0] - 4'h1;
    r = {p[6], p[2:0]};
    r = up ? r + 4'h1 : r - 4'h1;
    if (glyph) begin
      step_ptr = {2'h0, g};
    end else if (split) begin
      step_ptr = ring_addr(r);
    end else begin
      step_ptr = {3'h0, c};
    end
  endfunction

  logic [14:0] syn1_ff;
  logic [14:0] syn2_ff;
  logic [14:0] syn3_ff;
  logic [14:0] flt_ff;
  logic strb_d_ff;
  logic osc_d_ff;
  logic [7:0] div_ff;
  logic [8:0] rst_cnt_ff;
  logic nib_ff;
  logic [3:0] hi_ff;
  logic [6:0] ptr_ff;
  logic glyph_ff;
  logic bus8_ff;
  logic two_line_ff;
  logic split_ff;
  logic inc_ff;
  logic [3:0] off_ff;
  logic [7:0] xfer_ff;
  logic [3:0] busy_cnt_ff;
  clhp_pkg::clhp_state_t state_ff;
  clhp_pkg::clhp_state_t nxt_state;
  logic [7:0] bus_ff;
  logic [7:0] oe_ff;
  logic [6:0] line1_ff;
  logic [6:0] line2_ff;
  logic wait_ff;
  logic [7:0] ram_rdata;

  // a pin change counts once the second and third stages agree
  wire [14:0] pins = {i_ext_osc_en, i_pad_order_select, i_clock_in_pad,
                      i_reset_pad_b, i_strobe, i_rw_select, i_register_select, i_host_bus};
  wire [14:0] syn_diff = syn2_ff ^ syn3_ff;
  wire [14:0] nxt_flt = (syn2_ff & ~syn_diff) | (flt_ff & syn_diff);

  wire rs = flt_ff[P_RS];
  wire rw = flt_ff[P_RW];
  wire osc_tick = flt_ff[P_EXT] ? (flt_ff[P_OSC] & ~osc_d_ff) : (div_ff == OSC_LAST);
  wire sys_rst = ~flt_ff[P_RST] & (rst_cnt_ff == RST_TICKS);
  wire busy = (state_ff != clhp_pkg::CLHP_IDLE);

  wire e_fall = strb_d_ff & ~flt_ff[P_E];
  wire take = e_fall & (bus8_ff | nib_ff);
  wire [7:0] byte_in = bus8_ff ? flt_ff[7:0] : {hi_ff, flt_ff[7:4]};
  // busy refuses every write and data read; status reads stay open
  wire cmd_wr = take & ~rs & ~rw & ~busy;
  wire dat_wr = take & rs & ~rw & ~busy;
  wire dat_rd = take & rs & rw & ~busy;
  wire set_dd = cmd_wr & byte_in[`CLHP_CMD_DD_BIT];
  wire set_cg = cmd_wr & ~byte_in[`CLHP_CMD_DD_BIT] & byte_in[`CLHP_CMD_CG_BIT];
  wire set_fn = cmd_wr & (byte_in[7:5] == 3'h1);
  wire set_sh = cmd_wr & (byte_in[7:4] == 4'h1);
  wire set_em = cmd_wr & (byte_in[7:2] == 6'h01);
  wire shift_disp = set_sh & byte_in[`CLHP_SH_DISP_BIT];
  wire shift_right = byte_in[`CLHP_SH_RIGHT_BIT];

  wire [6:0] nxt_ptr = set_dd ? byte_in[6:0] :
                       set_cg ? {2'h0, byte_in[4:0]} :
                       (dat_wr | dat_rd) ? step_ptr(ptr_ff, inc_ff, glyph_ff, split_ff) :
                       ptr_ff;
  wire [3:0] nxt_off = ~shift_disp ? off_ff :
                       shift_right ? off_ff - 4'h1 : off_ff + 4'h1;
  wire [3:0] off2 = off_ff + `CLHP_LINE2_OFS;
  wire [6:0] nxt_line1 = split_ff ? ring_addr(off_ff) : {3'h0, off_ff};
  wire [6:0] nxt_line2 = split_ff ? ring_addr(off2) : {3'h0, off2};

  // glyph words are five bits wide; upper bits stored as zero
  wire [5:0] ram_idx = glyph_ff ? {1'b1, ptr_ff[4:0]} :
                       {2'h0, split_ff ? {ptr_ff[6], ptr_ff[2:0]} : ptr_ff[3:0]};
  wire [7:0] ram_wdata = glyph_ff ? {3'h0, byte_in[4:0]} : byte_in;

  // status never shows the command register, only flag and pointer
  wire [7:0] rd_byte = rs ? xfer_ff : {busy, ptr_ff};
  wire drv = flt_ff[P_E] & rw;
  wire [7:0] nxt_bus = bus8_ff ? rd_byte :
                       {(nib_ff ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};
  wire [7:0] nxt_oe = ~drv ? 8'h00 : bus8_ff ? 8'hff : 8'hf0;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      clhp_pkg::CLHP_IDLE: begin
        if (set_dd | set_cg | dat_rd) begin
          nxt_state = clhp_pkg::CLHP_FETCH;
        end else if (cmd_wr | dat_wr) begin
          nxt_state = clhp_pkg::CLHP_HOLD;
        end
      end
      clhp_pkg::CLHP_FETCH: nxt_state = clhp_pkg::CLHP_CAPTURE;
      clhp_pkg::CLHP_CAPTURE: nxt_state = clhp_pkg::CLHP_HOLD;
      clhp_pkg::CLHP_HOLD: begin
        if (osc_tick && busy_cnt_ff == BUSY_LAST) begin
          nxt_state = clhp_pkg::CLHP_IDLE;
        end
      end
      default: nxt_state = clhp_pkg::CLHP_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      syn1_ff <= SYN_RST;
      syn2_ff <= SYN_RST;
      syn3_ff <= SYN_RST;
      flt_ff <= SYN_RST;
    end else if (i_core_ce) begin
      syn1_ff <= pins;
      syn2_ff <= syn1_ff;
      syn3_ff <= syn2_ff;
      flt_ff <= nxt_flt;
    end
  end

  // oscillator divider and long-low reset measurement
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strb_d_ff <= 1'b0;
      osc_d_ff <= 1'b0;
      div_ff <= 8'h00;
      rst_cnt_ff <= 9'h000;
    end else if (i_core_ce) begin
      strb_d_ff <= flt_ff[P_E];
      osc_d_ff <= flt_ff[P_OSC];
      div_ff <= (div_ff == OSC_LAST) ? 8'h00 : div_ff + 8'h01;
      if (flt_ff[P_RST]) begin
        rst_cnt_ff <= 9'h000;
      end else if (osc_tick && rst_cnt_ff != RST_TICKS) begin
        rst_cnt_ff <= rst_cnt_ff + 9'h001;
      end
    end
  end

  // nibble pairing: high nibble first, byte completes on the second strobe
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nib_ff <= 1'b0;
      hi_ff <= 4'h0;
    end else if (i_core_ce) begin
      if (sys_rst || bus8_ff) begin
        nib_ff <= 1'b0;
      end else if (e_fall) begin
        nib_ff <= ~nib_ff;
        hi_ff <= flt_ff[7:4];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus8_ff <= `CLHP_RST_BUS8;
      two_line_ff <= 1'b0;
      split_ff <= 1'b0;
      inc_ff <= `CLHP_RST_INC;
      off_ff <= 4'h0;
    end else if (i_core_ce) begin
      if (sys_rst) begin
        bus8_ff <= `CLHP_RST_BUS8;
        two_line_ff <= 1'b0;
        split_ff <= 1'b0;
        inc_ff <= `CLHP_RST_INC;
        off_ff <= 4'h0;
      end else begin
        if (set_fn) begin
          bus8_ff <= byte_in[`CLHP_FN_BUS8_BIT];
          two_line_ff <= byte_in[`CLHP_FN_TWO_BIT];
          split_ff <= byte_in[`CLHP_FN_SPLIT_BIT];
        end
        if (set_em) begin
          inc_ff <= byte_in[`CLHP_EM_INC_BIT];
        end
        off_ff <= nxt_off;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_ff <= 7'h00;
      glyph_ff <= 1'b0;
      xfer_ff <= 8'h00;
      state_ff <= clhp_pkg::CLHP_IDLE;
      busy_cnt_ff <= 4'h0;
    end else if (i_core_ce) begin
      if (sys_rst) begin
        ptr_ff <= 7'h00;
        glyph_ff <= 1'b0;
        xfer_ff <= 8'h00;
        state_ff <= clhp_pkg::CLHP_IDLE;
        busy_cnt_ff <= 4'h0;
      end else begin
        ptr_ff <= nxt_ptr;
        glyph_ff <= set_cg | (glyph_ff & ~set_dd);
        if (dat_wr) begin
          xfer_ff <= ram_wdata;
        end else if (state_ff == clhp_pkg::CLHP_CAPTURE) begin
          xfer_ff <= ram_rdata;
        end
        state_ff <= nxt_state;
        if (state_ff != clhp_pkg::CLHP_HOLD) begin
          busy_cnt_ff <= 4'h0;
        end else if (osc_tick) begin
          busy_cnt_ff <= busy_cnt_ff + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_ff <= 8'h00;
      oe_ff <= 8'h00;
      line1_ff <= 7'h00;
      line2_ff <= 7'h08;
      wait_ff <= 1'b0;
    end else if (i_core_ce) begin
      wait_ff <= ~sys_rst & (nxt_state != clhp_pkg::CLHP_IDLE);
      bus_ff <= nxt_bus;
      oe_ff <= nxt_oe;
      line1_ff <= nxt_line1;
      line2_ff <= nxt_line2;
    end
  end

  clhp_ram u_ram (
    .i_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_core_ce),
    .i_we(dat_wr & ~sys_rst),
    .i_addr(ram_idx),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  assign o_host_bus = bus_ff;
  assign o_host_bus_oe = oe_ff;
  assign o_pad_order_mirror = flt_ff[P_PAD];
  assign o_line_layout_select = two_line_ff;
  assign o_addr_split = split_ff;
  assign o_line1_start = line1_ff;
  assign o_line2_start = line2_ff;
  assign o_wait_flag = wait_ff;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  status_read_a: assert property (i_core_ce && drv && !rs && bus8_ff
    |=> o_host_bus == {$past(busy), $past(ptr_ff)})
    else $error("status read shows wrong flag or pointer");
  narrow_bus_a: assert property (i_core_ce && !bus8_ff |=> o_host_bus_oe[3:0] == 4'h0)
    else $error("lower lines driven in four-bit mode");
  strobe_drive_a: assert property (i_core_ce && !drv |=> o_host_bus_oe == 8'h00)
    else $error("bus driven outside a read strobe");
  write_busy_a: assert property (i_core_ce && dat_wr && !sys_rst |=> o_wait_flag)
    else $error("wait flag not raised after data write");
  ptr_step_a: assert property (i_core_ce && dat_wr && !sys_rst
    |=> ptr_ff == step_ptr($past(ptr_ff), $past(inc_ff), $past(glyph_ff), $past(split_ff)))
    else $error("pointer did not step after data write");
  addr_load_a: assert property (i_core_ce && set_dd && !sys_rst
    |=> ptr_ff == $past(byte_in[6:0]) && !glyph_ff)
    else $error("address command not loaded");
  prefetch_load_a: assert property (i_core_ce && !sys_rst && state_ff == clhp_pkg::CLHP_CAPTURE
    |=> xfer_ff == $past(ram_rdata))
    else $error("prefetch not captured");
  fetch_order_a: assert property (i_core_ce && !sys_rst && dat_rd
    |=> state_ff == clhp_pkg::CLHP_FETCH)
    else $error("data read did not start prefetch");
  pin_reset_a: assert property (i_core_ce && sys_rst
    |=> ptr_ff == 7'h00 && state_ff == clhp_pkg::CLHP_IDLE)
    else $error("long reset pin did not clear state");
  shift_left_a: assert property (i_core_ce && !sys_rst && shift_disp && !shift_right
    |=> off_ff == $past(off_ff) + 4'h1)
    else $error("left shift did not advance view");

  data_write_c: cover property (i_core_ce && dat_wr);
  status_read_c: cover property (i_core_ce && drv && !rs);
  shift_split_c: cover property (i_core_ce && shift_disp && split_ff);
  pin_reset_c: cover property (sys_rst);
endmodule // clhp_top
`default_nettype wire

// ---- include/clhp_params.svh ----
// constants for the character display host port
`ifndef CLHP_PARAMS_SVH
`define CLHP_PARAMS_SVH
`define CLHP_CLK_HZ 40000000
`define CLHP_OSC_HZ 270000
`define CLHP_OSC_DIV (`CLHP_CLK_HZ / `CLHP_OSC_HZ)
`define CLHP_RST_TIME_US 1200
`define CLHP_RST_TICKS ((`CLHP_RST_TIME_US * `CLHP_OSC_HZ + 999999) / 1000000)
`define CLHP_BUSY_TICKS 10
`define CLHP_CMD_DD_BIT 7
`define CLHP_CMD_CG_BIT 6
`define CLHP_FN_BUS8_BIT 4
`define CLHP_FN_TWO_BIT 3
`define CLHP_FN_SPLIT_BIT 2
`define CLHP_SH_DISP_BIT 3
`define CLHP_SH_RIGHT_BIT 2
`define CLHP_EM_INC_BIT 1
`define CLHP_STAT_WAIT_BIT 7
`define CLHP_LINE2_OFS 4'h8
`define CLHP_RST_BUS8 1'b1
`define CLHP_RST_INC 1'b1
`endif

// ---- include/clhp_pkg.sv ----
// types for the character display host port
package clhp_pkg;
  typedef enum logic [1:0] {
    CLHP_IDLE,
    CLHP_FETCH,
    CLHP_CAPTURE,
    CLHP_HOLD
  } clhp_state_t;
endpackage

// ---- design/clhp_ram.sv ----
// character and glyph storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module clhp_ram (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:63];
  logic [7:0] rdata_ff;

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff <= 8'h00;
    end else if (i_ce) begin
      rdata_ff <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_ff;
endmodule // clhp_ram
`default_nettype wire

// ---- verif/clhp_host_model.sv ----
// host microprocessor model driving the character display port
`timescale 1ns/1ps
`default_nettype none
module clhp_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_dut_bus,
  input wire logic [7:0] i_dut_oe,
  output logic o_register_select,
  output logic o_rw_select,
  output logic o_strobe,
  output logic [7:0] o_bus
);
  logic [7:0] drv = 8'h00;
  logic [7:0] hval = 8'h00;
  logic [7:0] prev = 8'h00;
  logic [7:0] last_oe = 8'h00;
  logic four = 1'b0;
  // released lines toggle every cycle so a stale value never looks valid
  assign o_bus = (i_dut_oe & i_dut_bus) | (~i_dut_oe & ((drv & hval) | (~drv & ~prev)));
  always_ff @(posedge i_core_clk) begin
    prev <= ~prev;
  end
  initial begin
    o_register_select = 1'b0;
    o_rw_select = 1'b0;
    o_strobe = 1'b0;
  end
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] d, input logic [7:0] m,
                       output logic [7:0] q);
    @(negedge i_core_clk);
    o_register_select = rs;
    o_rw_select = rw;
    hval = d;
    drv = rw ? 8'h00 : m;
    o_strobe = 1'b1;
    repeat (8) @(negedge i_core_clk);
    q = o_bus;
    last_oe = i_dut_oe;
    o_strobe = 1'b0;
    // hold data past the filtered fall before releasing
    repeat (6) @(negedge i_core_clk);
    drv = 8'h00;
  endtask
  task automatic access(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] a;
    logic [7:0] b;
    if (four) begin
      pulse(rs, rw, d, 8'hf0, a);
      pulse(rs, rw, {d[3:0], 4'h0}, 8'hf0, b);
      q = {a[7:4], b[7:4]};
    end else begin
      pulse(rs, rw, d, 8'hff, q);
    end
  endtask
  task automatic poll(output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h80;
    while (q[7] !== 1'b0 && n < 300) begin
      access(1'b0, 1'b1, 8'h00, q);
      n++;
    end
  endtask
endmodule // clhp_host_model
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the character display host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rs;
  logic rw;
  logic stb;
  logic [7:0] bus;
  logic [7:0] dout;
  logic [7:0] doe;
  logic ext_en = 1'b0;
  logic ce = 1'b1;
  logic pad_clk = 1'b0;
  logic pad_rst_b = 1'b1;
  logic pad_sel = 1'b0;
  logic mir;
  logic lay;
  logic spl;
  logic [6:0] l1;
  logic [6:0] l2;
  logic wt;
  logic [2:0] tick = 3'h0;
  logic [7:0] q;
  int bad_count = 0;
  int checked = 0;

  always #12.5 clk = ~clk;
  // external oscillator at a tenth of core rate keeps pad reset short
  always @(negedge clk) begin
    tick <= (tick == 3'h4) ? 3'h0 : tick + 3'h1;
    if (tick == 3'h4) begin
      pad_clk <= ~pad_clk;
    end
  end

  clhp_top i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_core_ce(ce), .i_register_select(rs),
    .i_rw_select(rw), .i_strobe(stb), .i_host_bus(bus), .o_host_bus(dout), .o_host_bus_oe(doe),
    .i_clock_in_pad(pad_clk), .i_ext_osc_en(ext_en), .i_reset_pad_b(pad_rst_b),
    .i_pad_order_select(pad_sel), .o_pad_order_mirror(mir), .o_line_layout_select(lay),
    .o_addr_split(spl), .o_line1_start(l1), .o_line2_start(l2), .o_wait_flag(wt));
  clhp_host_model i_host (.i_core_clk(clk), .i_dut_bus(dout), .i_dut_oe(doe),
    .o_register_select(rs), .o_rw_select(rw), .o_strobe(stb), .o_bus(bus));

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // a poll that gives up counts as a mismatch
  task automatic rdy();
    i_host.poll(q);
    chk("ready", {7'h00, q[7]}, 8'h00);
  endtask
  task automatic cmd(input logic [7:0] c);
    rdy();
    i_host.access(1'b0, 1'b0, c, q);
  endtask
  task automatic dwr(input logic [7:0] d);
    rdy();
    i_host.access(1'b1, 1'b0, d, q);
  endtask
  task automatic drd(output logic [7:0] r);
    rdy();
    i_host.access(1'b1, 1'b1, 8'h00, r);
  endtask
  task automatic st(input logic [7:0] e);
    i_host.poll(q);
    chk("status", q, e);
  endtask
  task automatic view(input logic [7:0] c, input logic [6:0] a, input logic [6:0] b);
    cmd(c);
    rdy();
    chk("line1", {1'b0, l1}, {1'b0, a});
    chk("line2", {1'b0, l2}, {1'b0, b});
  endtask
  task automatic busy_len(output int n);
    n = 0;
    while (wt === 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic pad_reset(input int c);
    pad_rst_b = 1'b0;
    repeat (c) @(negedge clk);
    pad_rst_b = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic t_reset();
    chk("line1", {1'b0, l1}, 8'h00);
    chk("line2", {1'b0, l2}, 8'h08);
    chk("oe", doe, 8'h00);
    chk("modes", {6'h00, lay, spl}, 8'h00);
    st(8'h00);
  endtask
  task automatic t_data();
    cmd(8'h83);
    dwr(8'ha5);
    dwr(8'h5a);
    st(8'h05);
    cmd(8'h83);
    drd(q);
    chk("prefetch", q, 8'ha5);
    drd(q);
    chk("next", q, 8'h5a);
    st(8'h05);
  endtask
  task automatic t_busy();
    int n;
    cmd(8'h06);
    i_host.access(1'b0, 1'b1, 8'h00, q);
    chk("busy status", q, 8'h85);
    busy_len(n);
    chk("busy len", 8'(n > 1300 && n < 1490), 8'h01);
  endtask
  task automatic t_dec();
    cmd(8'h04);
    cmd(8'h82);
    dwr(8'h11);
    st(8'h01);
    cmd(8'h06);
  endtask
  task automatic t_wrap();
    cmd(8'h8f);
    dwr(8'h22);
    st(8'h00);
    cmd(8'h4f);
    dwr(8'hff);
    st(8'h10);
    cmd(8'h4f);
    drd(q);
    chk("glyph", q, 8'h1f);
  endtask
  task automatic t_shift();
    view(8'h38, 7'h00, 7'h08);
    chk("layout", {6'h00, lay, spl}, 8'h02);
    view(8'h1c, 7'h0f, 7'h07);
    view(8'h18, 7'h00, 7'h08);
    view(8'h18, 7'h01, 7'h09);
    view(8'h1c, 7'h00, 7'h08);
    view(8'h3c, 7'h00, 7'h40);
    view(8'h1c, 7'h47, 7'h07);
    view(8'h18, 7'h00, 7'h40);
    view(8'h18, 7'h01, 7'h41);
    cmd(8'h87);
    dwr(8'h33);
    st(8'h40);
  endtask
  task automatic t_nibble();
    cmd(8'h28);
    i_host.four = 1'b1;
    cmd(8'h81);
    dwr(8'hc3);
    cmd(8'h81);
    drd(q);
    chk("nibble read", q, 8'hc3);
    chk("nibble oe", i_host.last_oe, 8'hf0);
    cmd(8'h30);
    i_host.four = 1'b0;
    st(8'h02);
    chk("byte oe", i_host.last_oe, 8'hff);
  endtask
  task automatic t_pads();
    int n;
    pad_sel = 1'b1;
    repeat (8) @(negedge clk);
    chk("mirror", {7'h00, mir}, 8'h01);
    // enable low must freeze even the pin filters
    ce = 1'b0;
    pad_sel = 1'b0;
    repeat (8) @(negedge clk);
    chk("frozen mirror", {7'h00, mir}, 8'h01);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    chk("mirror", {7'h00, mir}, 8'h00);
    ext_en = 1'b1;
    cmd(8'h06);
    busy_len(n);
    chk("ext busy", 8'(n > 80 && n < 110), 8'h01);
    cmd(8'h85);
    pad_reset(3000);
    st(8'h05);
    pad_reset(3600);
    st(8'h00);
    chk("line2", {1'b0, l2}, 8'h08);
    ext_en = 1'b0;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    t_reset();
    t_data();
    t_busy();
    t_dec();
    t_wrap();
    t_shift();
    t_nibble();
    t_pads();
    end_of_test();
  end
  initial begin
    #2250000;
    bad_count++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
